// ### rtl/ctsm_top.sv
// Contract
// [R1] load-mod test code 00 drives the pin low, 01 high, 11 the selected test-bus bit, 10 reserved.
// [R2] the test code reaches the load-mod pin only while the load-mod source select is 1.
// [R3] secure clock source 00 is off, 01 oscillator, 10 core clock, 11 rf-recovered clock.
// [R4] with bit 3 and observe enable both 1 the secure clock goes to the shared transmit pin.
// [R5] bits 2..0 pick one test-bus bit, which feeds load-mod test code 11.
// [R6] test pin values form a 7-bit bus driven onto or read from the shared test pins.
// [R7] each test pin is driven from its value only while its enable bit is set.
// [R8] reading the test bus register returns the live internal test bus.
// [R9] reading the adc register returns the live receiver adc i and q values.
// [R10] registers are 8 bits, read back, read-only writes are ignored, code 10 drives low; the pin value register reads back the pin levels instead.
`timescale 1ns/100ps
`default_nettype none
module ctsm_top
  import ctsm_pkg::*;
#(
  parameter logic [7:0] REVISION = ctsm_pkg::CTSM_REVISION_DEF
)(
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [17:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // core context
  input wire logic load_mod_source_sel_i,
  input wire logic observe_en_i,
  input wire logic [7:0] test_bus_i,
  input wire logic [3:0] adc_i_i,
  input wire logic [3:0] adc_q_i,
  // secure clock candidates
  input wire logic osc_clk_i,
  input wire logic core_clk_i,
  input wire logic rf_clk_i,
  // outputs
  output logic load_mod_pin_o,
  output logic secure_clk_o,
  output logic shared_port_transmit_pin_o,
  output logic shared_port_transmit_pin_oe_o,
  // test pins
  input wire logic [ctsm_pkg::CTSM_PINS-1:0] test_pin_i,
  output logic [ctsm_pkg::CTSM_PINS-1:0] test_pin_o,
  output logic [ctsm_pkg::CTSM_PINS-1:0] test_pin_oe_o,
  // analogue test controls
  output logic [7:0] self_test_ctrl_o,
  output logic [7:0] analog_ctrl_o,
  output logic [7:0] dac_one_o,
  output logic [7:0] dac_two_o,
  output logic [7:0] sel_two_o
);
  import ctsm_pkg::*;

  logic [7:0] sel_one_reg;
  logic [7:0] sel_two_reg;
  logic [7:0] pin_en_reg;
  logic [7:0] pin_val_reg;
  logic [7:0] self_test_reg;
  logic [7:0] analog_reg;
  logic [7:0] dac_one_reg;
  logic [7:0] dac_two_reg;
  logic [15:0] idx;
  logic req;
  logic wr;
  logic [7:0] rd_next;
  logic lm_next;
  logic sclk_next;
  logic tb_bit;

  // word index: byte address divided by four
  assign idx = wb_adr_i[17:2];
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = req && wb_we_i && wb_sel_i[0];

  // writable registers; read-only indices are not decoded here so writes drop
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sel_one_reg <= CTSM_RST_VAL;
      sel_two_reg <= CTSM_RST_VAL;
      pin_en_reg <= CTSM_RST_VAL;
      pin_val_reg <= CTSM_RST_VAL;
      self_test_reg <= CTSM_RST_VAL;
      analog_reg <= CTSM_RST_VAL;
      dac_one_reg <= CTSM_RST_VAL;
      dac_two_reg <= CTSM_RST_VAL;
    end
    else if (ce_i && wr)
    begin
      if (idx == CTSM_IDX_SEL_ONE)
        sel_one_reg <= wb_dat_i[7:0];
      else if (idx == CTSM_IDX_SEL_TWO)
        sel_two_reg <= wb_dat_i[7:0];
      else if (idx == CTSM_IDX_PIN_EN)
        pin_en_reg <= wb_dat_i[7:0];
      else if (idx == CTSM_IDX_PIN_VAL)
        pin_val_reg <= wb_dat_i[7:0];
      else if (idx == CTSM_IDX_SELF_TEST)
        self_test_reg <= wb_dat_i[7:0];
      else if (idx == CTSM_IDX_ANALOG)
        analog_reg <= wb_dat_i[7:0];
      else if (idx == CTSM_IDX_DAC_ONE)
        dac_one_reg <= wb_dat_i[7:0];
      else if (idx == CTSM_IDX_DAC_TWO)
        dac_two_reg <= wb_dat_i[7:0];
    end
  end

  // read mux; live status is sampled at the ack edge
  always_comb
  begin
    rd_next = 8'h00;
    if (idx == CTSM_IDX_SEL_ONE)
      rd_next = sel_one_reg; // see [R10]
    else if (idx == CTSM_IDX_SEL_TWO)
      rd_next = sel_two_reg;
    else if (idx == CTSM_IDX_PIN_EN)
      rd_next = pin_en_reg;
    else if (idx == CTSM_IDX_PIN_VAL)
      rd_next = {1'b0, test_pin_i}; // pin levels; see [R6]
    else if (idx == CTSM_IDX_BUS_RD)
      rd_next = test_bus_i; // see [R8]
    else if (idx == CTSM_IDX_SELF_TEST)
      rd_next = self_test_reg;
    else if (idx == CTSM_IDX_REVISION)
      rd_next = REVISION;
    else if (idx == CTSM_IDX_ANALOG)
      rd_next = analog_reg;
    else if (idx == CTSM_IDX_DAC_ONE)
      rd_next = dac_one_reg;
    else if (idx == CTSM_IDX_DAC_TWO)
      rd_next = dac_two_reg;
    else if (idx == CTSM_IDX_ADC_RD)
      rd_next = {adc_i_i, adc_q_i}; // see [R9]
  end

  // one-wait-state ack; unmapped reads give zero and still ack
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      wb_ack_o <= req;
      if (req && !wb_we_i)
        wb_dat_o <= {24'h00_0000, rd_next};
    end
  end

  // test-bus bit pick
  assign tb_bit = test_bus_i[sel_one_reg[CTSM_TBSEL_HI:CTSM_TBSEL_LO]]; // see [R5]

  // load-mod pin source
  always_comb
  begin
    lm_next = 1'b0;
    if (load_mod_source_sel_i) // see [R2]
    begin
      case (sel_one_reg[CTSM_LM_TST_HI:CTSM_LM_TST_LO])
        CTSM_LM_LOW: lm_next = 1'b0; // see [R1]
        CTSM_LM_HIGH: lm_next = 1'b1;
        CTSM_LM_BUS: lm_next = tb_bit;
        default: lm_next = 1'b0; // reserved code held low; see [R10]
      endcase
    end
  end

  // secure clock selection; registered, so output toggles at most at clk_i/2
  always_comb
  begin
    case (sel_one_reg[CTSM_SCLK_HI:CTSM_SCLK_LO])
      CTSM_SCLK_OFF: sclk_next = 1'b0; // see [R3]
      CTSM_SCLK_OSC: sclk_next = osc_clk_i;
      CTSM_SCLK_CORE: sclk_next = core_clk_i;
      default: sclk_next = rf_clk_i;
    endcase
  end

  // pin drive flops
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      load_mod_pin_o <= 1'b0;
      secure_clk_o <= 1'b0;
      shared_port_transmit_pin_o <= 1'b0;
      shared_port_transmit_pin_oe_o <= 1'b0;
      test_pin_o <= '0;
      test_pin_oe_o <= '0;
    end
    else if (ce_i)
    begin
      load_mod_pin_o <= lm_next;
      secure_clk_o <= sclk_next;
      shared_port_transmit_pin_o <= sclk_next;
      shared_port_transmit_pin_oe_o <= sel_one_reg[CTSM_SCLK_OUT_BIT] && observe_en_i; // see [R4]
      test_pin_o <= pin_val_reg[CTSM_PINS-1:0]; // see [R6]
      test_pin_oe_o <= pin_en_reg[CTSM_PINS-1:0]; // see [R7]
    end
  end

  // control outputs straight from registers
  assign self_test_ctrl_o = self_test_reg;
  assign analog_ctrl_o = analog_reg;
  assign dac_one_o = dac_one_reg;
  assign dac_two_o = dac_two_reg;
  assign sel_two_o = sel_two_reg;
endmodule : ctsm_top
`default_nettype wire

// ### shared/ctsm_pkg.sv
`default_nettype none
package ctsm_pkg;
  // register offsets: printed offsets are not all multiples of four, so they are indices
  localparam logic [15:0] CTSM_IDX_SEL_ONE = 16'h6321;
  localparam logic [15:0] CTSM_IDX_SEL_TWO = 16'h6322;
  localparam logic [15:0] CTSM_IDX_PIN_EN = 16'h6323;
  localparam logic [15:0] CTSM_IDX_PIN_VAL = 16'h6324;
  localparam logic [15:0] CTSM_IDX_BUS_RD = 16'h6325;
  localparam logic [15:0] CTSM_IDX_SELF_TEST = 16'h6326;
  localparam logic [15:0] CTSM_IDX_REVISION = 16'h6327;
  localparam logic [15:0] CTSM_IDX_ANALOG = 16'h6328;
  localparam logic [15:0] CTSM_IDX_DAC_ONE = 16'h6329;
  localparam logic [15:0] CTSM_IDX_DAC_TWO = 16'h632a;
  localparam logic [15:0] CTSM_IDX_ADC_RD = 16'h632b;
  // field positions in test_signal_select_one
  localparam int CTSM_LM_TST_HI = 7;
  localparam int CTSM_LM_TST_LO = 6;
  localparam int CTSM_SCLK_HI = 5;
  localparam int CTSM_SCLK_LO = 4;
  localparam int CTSM_SCLK_OUT_BIT = 3;
  localparam int CTSM_TBSEL_HI = 2;
  localparam int CTSM_TBSEL_LO = 0;
  // load-modulation test codes
  localparam logic [1:0] CTSM_LM_LOW = 2'h0;
  localparam logic [1:0] CTSM_LM_HIGH = 2'h1;
  localparam logic [1:0] CTSM_LM_RSVD = 2'h2;
  localparam logic [1:0] CTSM_LM_BUS = 2'h3;
  // secure clock source codes
  localparam logic [1:0] CTSM_SCLK_OFF = 2'h0;
  localparam logic [1:0] CTSM_SCLK_OSC = 2'h1;
  localparam logic [1:0] CTSM_SCLK_CORE = 2'h2;
  localparam logic [1:0] CTSM_SCLK_RF = 2'h3;
  // reset value of every writable register
  localparam logic [7:0] CTSM_RST_VAL = 8'h00;
  // revision code, value is arbitrary
  localparam logic [7:0] CTSM_REVISION_DEF = 8'h5a;
  // test pin count
  localparam int CTSM_PINS = 7;
endpackage : ctsm_pkg
`default_nettype wire

// ### sim/contactless_test_signal_mux_test.sv
`timescale 1ns/100ps
`default_nettype none
module contactless_test_signal_mux_test;
  import ctsm_pkg::*;
  typedef struct {logic [15:0] ix; logic [7:0] wv; logic [7:0] ev;} ctsm_row_t;
  logic clk_i = 0, rst_i = 1, ce_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
  logic load_mod_source_sel_i = 1, observe_en_i = 1, osc_clk_i = 1, core_clk_i = 0, rf_clk_i = 1;
  logic load_mod_pin_o, secure_clk_o, shared_port_transmit_pin_o, shared_port_transmit_pin_oe_o;
  logic [17:0] wb_adr_i = 0;
  logic [3:0] wb_sel_i = 0, adc_i_i = 4'h9, adc_q_i = 4'h6;
  logic [31:0] wb_dat_i = 0, wb_dat_o, rdo;
  logic [7:0] test_bus_i = 8'h08, self_test_ctrl_o, analog_ctrl_o, dac_one_o, dac_two_o, sel_two_o;
  logic [6:0] test_pin_i = 7'h55, test_pin_o, test_pin_oe_o;
  int miscompares = 0, samples_checked = 0;
  // read-only rows expect the live source or the revision code, not the written byte
  ctsm_row_t rows [9] = '{'{CTSM_IDX_SEL_TWO, 8'ha5, 8'ha5}, '{CTSM_IDX_PIN_EN, 8'h7f, 8'h7f},
    '{CTSM_IDX_SELF_TEST, 8'h3c, 8'h3c}, '{CTSM_IDX_ANALOG, 8'h81, 8'h81},
    '{CTSM_IDX_DAC_ONE, 8'hff, 8'hff}, '{CTSM_IDX_DAC_TWO, 8'h01, 8'h01},
    '{CTSM_IDX_BUS_RD, 8'hff, 8'h08}, '{CTSM_IDX_REVISION, 8'hff, CTSM_REVISION_DEF},
    '{CTSM_IDX_ADC_RD, 8'hff, 8'h96}};
  ctsm_top uut (.*);
  always #2.5 clk_i = ~clk_i;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // one classic cycle, then an idle cycle so requests never abut
  task automatic bus(input logic w, input logic [15:0] ix, input logic [7:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1; wb_stb_i <= 1; wb_we_i <= w; wb_sel_i <= 4'h1;
    wb_adr_i <= {ix, 2'h0}; wb_dat_i <= {24'h0, d};
    do begin @(posedge clk_i); n++; end while (wb_ack_o !== 1'b1 && n < 20);
    rdo = wb_dat_o;
    wb_cyc_i <= 0; wb_stb_i <= 0; wb_we_i <= 0;
    @(posedge clk_i);
    if (n >= 20) miscompares++;
  endtask : bus
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : complete_run
  // watchdog far beyond the hundred or so cycles the sequence needs
  initial
  begin
    #20000 miscompares++;
    complete_run;
  end
  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    bus(0, CTSM_IDX_SEL_TWO, 0); chk(rdo, 0);
    foreach (rows[k])
    begin
      bus(1, rows[k].ix, rows[k].wv);
      bus(0, rows[k].ix, 0); chk(rdo, {24'h0, rows[k].ev});
    end
    // control outputs must carry the bytes written by the rows
    chk(sel_two_o, 8'ha5);
    chk(self_test_ctrl_o, 8'h3c);
    chk(analog_ctrl_o, 8'h81);
    chk(dac_one_o, 8'hff);
    chk(dac_two_o, 8'h01);
    bus(0, CTSM_IDX_PIN_VAL, 0); chk(rdo, 32'h55);
    chk(test_pin_oe_o, 7'h7f);
    bus(1, CTSM_IDX_PIN_VAL, 8'h2a); chk(test_pin_o, 7'h2a);
    bus(0, 16'h6330, 0); chk(rdo, 0);
    // load-mod and secure clock codes; test-bus bit 3 is high, candidates osc=1 core=0 rf=1
    for (int c = 0; c < 4; c++)
    begin
      bus(1, CTSM_IDX_SEL_ONE, {c[1:0], c[1:0], 4'hb});
      chk(load_mod_pin_o, c[0]);
      chk(secure_clk_o, 4'ha >> c & 1);
      chk(shared_port_transmit_pin_o, 4'ha >> c & 1);
      chk(shared_port_transmit_pin_oe_o, 1);
    end
    // code 11 picking test-bus bit 0, which is low
    bus(1, CTSM_IDX_SEL_ONE, 8'hc8); chk(load_mod_pin_o, 0);
    // source select off: the high code must not reach the pin
    load_mod_source_sel_i <= 0;
    bus(1, CTSM_IDX_SEL_ONE, 8'h48); chk(load_mod_pin_o, 0);
    load_mod_source_sel_i <= 1;
    repeat (2) @(posedge clk_i);
    chk(load_mod_pin_o, 1);
    observe_en_i <= 0;
    repeat (2) @(posedge clk_i);
    chk(shared_port_transmit_pin_oe_o, 0);
    rst_i <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    bus(0, CTSM_IDX_SEL_ONE, 0); chk(rdo, 0);
    complete_run;
  end
endmodule : contactless_test_signal_mux_test
`default_nettype wire

// ### sim/ctsm_checker.sv
`timescale 1ns/100ps
`default_nettype none
module ctsm_checker
  import ctsm_pkg::*;
(
  // bus side
  input wire logic clk_i, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
  input wire logic [17:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i, wb_dat_o,
  // core side
  input wire logic load_mod_source_sel_i, observe_en_i, load_mod_pin_o,
  input wire logic shared_port_transmit_pin_oe_o,
  input wire logic [7:0] test_bus_i,
  input wire logic [3:0] adc_i_i, adc_q_i,
  input wire logic [6:0] test_pin_i, test_pin_oe_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // taken request split by direction; multi-cycle checks assume ce_i stays high
  wire logic tk = wb_cyc_i & wb_stb_i & !wb_ack_o & ce_i;
  wire logic rd = tk & !wb_we_i;
  wire logic wr = tk & wb_we_i & wb_sel_i[0];
  wire logic [15:0] ix = wb_adr_i[17:2];
  AST_ACK_NEXT: assert property (tk |=> wb_ack_o) else $error("ack late");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  AST_DAT_UPPER: assert property (wb_dat_o[31:8] == 24'h0) else $error("upper data set");
  AST_BUS_READ: assert property (rd && ix == CTSM_IDX_BUS_RD |=>
    wb_dat_o[7:0] == $past(test_bus_i)) else $error("test bus read wrong");
  AST_ADC_READ: assert property (rd && ix == CTSM_IDX_ADC_RD |=>
    wb_dat_o[7:0] == {$past(adc_i_i), $past(adc_q_i)}) else $error("adc read wrong");
  AST_PIN_READ: assert property (rd && ix == CTSM_IDX_PIN_VAL |=>
    wb_dat_o[7:0] == {1'b0, $past(test_pin_i)}) else $error("pin read wrong");
  AST_PIN_ENABLE: assert property (wr && ix == CTSM_IDX_PIN_EN |-> ##2
    test_pin_oe_o == $past(wb_dat_i[6:0], 2)) else $error("pin enable wrong");
  AST_LM_HIGH: assert property (wr && ix == CTSM_IDX_SEL_ONE && wb_dat_i[7:6] == 2'h1
    && load_mod_source_sel_i ##1 load_mod_source_sel_i [*2] |-> load_mod_pin_o)
    else $error("load mod not high");
  AST_OBS_OFF: assert property (!observe_en_i |=> !shared_port_transmit_pin_oe_o)
    else $error("transmit pin driven");
endmodule : ctsm_checker
bind ctsm_top ctsm_checker chk (.*);
`default_nettype wire
